/* lrt_consts.vh */
`ifndef LRT_CONSTS_VH
`define LRT_CONSTS_VH
// ************************************************************
// Register map
// ************************************************************
`define LRT_REG_CTRL       8'h00
`define LRT_REG_TOKENS     8'h04
`define LRT_REG_STATUS     8'h08
`define LRT_REG_RETRIES    8'h0C
// ************************************************************
// Fields and reset values
// ************************************************************
`define LRT_RX_THRESH_LSB  0
`define LRT_TX_COUNT_LSB   8
`define LRT_RX_THRESH_RST  8'h10
`define LRT_TX_COUNT_RST   8'h14
`define LRT_TOKENS_RST     10'h000
`define LRT_FRP_BEGIN_BIT  0
`define LRT_FRP_CLEAR_BIT  1
`define LRT_PTR_W          8
`define LRT_BUF_USED_MAX   8'hFD
// ************************************************************
// Timing
// ************************************************************
`define LRT_ABORT_WAIT_CYC 8'd250
`define LRT_RUN_LIMIT      8'h40
// ************************************************************
// Bus answers
// ************************************************************
`define LRT_RESP_OKAY      2'b00
`define LRT_RESP_DECERR    2'b11
`endif

/* lrt_far_model.sv */
`timescale 1ns/1ps
`default_nettype none
// ************
// Far memory device model
// ************
module lrt_far_model #(
  parameter int DW = 256,
  parameter int TH = 4
) (
  input  wire logic          clk,
  input  wire logic          linkTxValid,
  input  wire logic          linkTxRetryPkt,
  input  wire logic [7:0]    linkTxFrp,
  input  wire logic [7:0]    linkTxRrp,
  output var  logic [DW-1:0] rxWordData,
  output var  logic          rxWordValid,
  output var  logic          rxRetryPkt,
  output var  logic          rxError,
  output var  logic [7:0]    rxFrp,
  output var  logic [7:0]    rxRrp,
  output var  logic          tokenReturnValid,
  output var  logic [9:0]    tokenReturnCount
);
  bit            lose = 1'b0;
  bit            stall = 1'b0;
  int            nb = 0;
  logic [7:0]    ack = 8'h00;
  logic [7:0]    seq = 8'h01;
  logic [DW-1:0] qd[$];
  logic [7:0]    qf[$];
  // Words lost to our own error are never acknowledged
  always @(posedge clk) begin
    if (linkTxValid && !linkTxRetryPkt && !lose) ack <= linkTxFrp + 8'h01;
    nb <= (linkTxValid && linkTxRetryPkt && linkTxFrp[0]) ? nb + 1 : 0;
  end
  task automatic put(input logic [DW-1:0] d, input logic rp, e, input logic [7:0] f);
    rxWordData <= d;
    rxWordValid <= 1'b1;
    rxRetryPkt <= rp;
    rxError <= e;
    rxFrp <= f;
    rxRrp <= ack;
    @(posedge clk);
  endtask
  // Idle lines toggle so a stale word cannot pass for a fresh one
  task automatic idle();
    rxWordValid <= 1'b0;
    rxWordData <= ~rxWordData;
    rxError <= ~rxError;
    rxFrp <= ~rxFrp;
    @(posedge clk);
  endtask
  // Data words carry forward pointer and stay queued for good; only unacknowledged ones are resent
  task automatic send(input logic [DW-1:0] d, input logic e);
    qd.push_back(d);
    qf.push_back(seq);
    put(d, 1'b0, e, seq);
    seq++;
    idle();
  endtask
  // Series of retry packets, flag in forward pointer
  task automatic series(input logic [1:0] fl, input int n);
    repeat (n) put({DW{1'b0}}, 1'b1, 1'b0, {6'h00, fl});
    idle();
  endtask
  task automatic tokens(input logic [9:0] n);
    tokenReturnValid <= 1'b1;
    tokenReturnCount <= n;
    @(posedge clk);
    tokenReturnValid <= 1'b0;
    tokenReturnCount <= ~n;
  endtask
  // Answer a retry request: clear series, then resend unacknowledged
  initial begin
    rxWordData = {DW{1'b0}};
    {rxWordValid, rxRetryPkt, rxError, rxFrp, rxRrp} = 19'h00000;
    {tokenReturnValid, tokenReturnCount} = 11'h000;
    forever begin
      @(posedge clk);
      if (nb == TH && !stall) begin
        series(2'b10, TH);
        foreach (qd[i]) if (qf[i] > linkTxRrp) put(qd[i], 1'b0, 1'b0, qf[i]);
        idle();
      end
    end
  end
endmodule // lrt_far_model
`default_nettype wire

/* lrt_link_retry.v */
`timescale 1ns/1ps
`default_nettype none
`include "lrt_consts.vh"
// Behaviour
// - Receiver of a packet with link error enters error-abort state.
// - Forward and return pointers built and checked the same on both ends.
// - Begin-retry packet has forward pointer bit 0 set.
// - At receive threshold of begin-retry, transmit series of error-clear packets.
// - Then replay buffer from last return pointer until read equals write.
// - Replayed words stay in the buffer for a later retry.
// - Receive error requests retry; transmit sends begin-retry packets.
// - In error-abort, all incoming packets except retry packets are dropped until cleared.
// - Error-abort still set after 250 cycles sends another begin-retry series.
// - Retry packets sent per type not below the peer's receive threshold.
// - Datapath width sets flits per word and its log.
// - New words accepted only while the far input buffer's tokens allow; replayed words are sent without a token check.
// - Sent count measured in the shift-out cycle, sampled a cycle later.
// - DC-coupled far receiver omits the run-length limiter.
// - Reset defaults 0x10 receive threshold, 0x14 send count.
// - Transmit link retries counted in a readable 32-bit counter.
module lrt_link_retry #(
  parameter DATAPATH_WIDTH          = 512,
  parameter FAR_RECEIVER_AC_COUPLED = 1
) (
  input  wire                      clk,
  input  wire                      rst,
  input  wire [7:0]                s_axi_awaddr,
  input  wire                      s_axi_awvalid,
  output reg                       s_axi_awready,
  input  wire [31:0]               s_axi_wdata,
  input  wire [3:0]                s_axi_wstrb,
  input  wire                      s_axi_wvalid,
  output reg                       s_axi_wready,
  output reg  [1:0]                s_axi_bresp,
  output reg                       s_axi_bvalid,
  input  wire                      s_axi_bready,
  input  wire [7:0]                s_axi_araddr,
  input  wire                      s_axi_arvalid,
  output reg                       s_axi_arready,
  output reg  [31:0]               s_axi_rdata,
  output reg  [1:0]                s_axi_rresp,
  output reg                       s_axi_rvalid,
  input  wire                      s_axi_rready,
  input  wire [DATAPATH_WIDTH-1:0] txWordData,
  input  wire                      txWordValid,
  output reg                       txWordReady,
  output reg  [DATAPATH_WIDTH-1:0] linkTxData,
  output reg                       linkTxValid,
  output reg                       linkTxRetryPkt,
  output reg  [7:0]                linkTxFrp,
  output reg  [7:0]                linkTxRrp,
  input  wire [DATAPATH_WIDTH-1:0] rxWordData,
  input  wire                      rxWordValid,
  input  wire                      rxRetryPkt,
  input  wire                      rxError,
  input  wire [7:0]                rxFrp,
  input  wire [7:0]                rxRrp,
  output reg  [DATAPATH_WIDTH-1:0] rxOutData,
  output reg                       rxOutValid,
  input  wire                      tokenReturnValid,
  input  wire [9:0]                tokenReturnCount,
  output reg                       errorAbort
);
  // ********************
  // Width derived constants
  // ********************
  function [3:0] fpwOf;
    input integer w;
    begin
      case (w)
        256:     fpwOf = 4'h2;
        512:     fpwOf = 4'h4;
        768:     fpwOf = 4'h6;
        default: fpwOf = 4'h8;
      endcase
    end
  endfunction

  function [2:0] fpwLogOf;
    input integer w;
    begin
      case (w)
        256:     fpwLogOf = 3'h1;
        512:     fpwLogOf = 3'h2;
        default: fpwLogOf = 3'h3;
      endcase
    end
  endfunction

  function [3:0] regSel;
    input [7:0] a;
    begin
      case (a)
        `LRT_REG_CTRL:    regSel = 4'h1;
        `LRT_REG_TOKENS:  regSel = 4'h2;
        `LRT_REG_STATUS:  regSel = 4'h4;
        `LRT_REG_RETRIES: regSel = 4'h8;
        default:          regSel = 4'h0;
      endcase
    end
  endfunction

  localparam [3:0] FLITS_PER_WORD     = fpwOf(DATAPATH_WIDTH);
  localparam [2:0] FLITS_PER_WORD_LOG = fpwLogOf(DATAPATH_WIDTH);

  localparam [3:0] ST_NORM   = 4'b0001;
  localparam [3:0] ST_BEGIN  = 4'b0010;
  localparam [3:0] ST_CLEAR  = 4'b0100;
  localparam [3:0] ST_REPLAY = 4'b1000;

  // ********************
  // Register bus
  // ********************
  reg [7:0]  awAddr_reg;
  reg        awHave_reg;
  reg [31:0] wData_reg;
  reg [3:0]  wStrb_reg;
  reg        wHave_reg;
  reg [7:0]  rxThresh_reg;
  reg [7:0]  txCount_reg;
  reg [9:0]  tokens_reg;
  reg [31:0] retries_reg;
  reg [3:0]  state_reg;
  wire [3:0] wrSel = regSel(awAddr_reg);
  wire [3:0] rdSel = regSel(s_axi_araddr);
  wire       doWrite = awHave_reg & wHave_reg & ~s_axi_bvalid;
  wire       tokLoad = doWrite & wrSel[1] & wStrb_reg[0];
  reg [31:0] rdMux;

  always @* begin
    rdMux = 32'h0000_0000;
    case (rdSel)
      4'h1: rdMux = {16'h0000, txCount_reg, rxThresh_reg};
      4'h2: rdMux = {22'h000000, tokens_reg};
      4'h4: rdMux = {16'h0000, FLITS_PER_WORD, 1'b0, FLITS_PER_WORD_LOG,
                     2'b00, state_reg, ~state_reg[0], errorAbort};
      4'h8: rdMux = retries_reg;
      default: rdMux = 32'h0000_0000;
    endcase
  end

  always @(posedge clk) begin
    if (rst) begin
      s_axi_awready <= 1'b0;
      s_axi_wready  <= 1'b0;
      s_axi_bvalid  <= 1'b0;
      s_axi_bresp   <= `LRT_RESP_OKAY;
      s_axi_arready <= 1'b0;
      s_axi_rvalid  <= 1'b0;
      s_axi_rresp   <= `LRT_RESP_OKAY;
      s_axi_rdata   <= 32'h0000_0000;
      awHave_reg    <= 1'b0;
      wHave_reg     <= 1'b0;
      awAddr_reg    <= 8'h00;
      wData_reg     <= 32'h0000_0000;
      wStrb_reg     <= 4'h0;
      rxThresh_reg  <= `LRT_RX_THRESH_RST;
      txCount_reg   <= `LRT_TX_COUNT_RST;
    end else begin
      s_axi_awready <= s_axi_awvalid & ~s_axi_awready & ~awHave_reg;
      s_axi_wready  <= s_axi_wvalid & ~s_axi_wready & ~wHave_reg;
      if (s_axi_awvalid & s_axi_awready) begin
        awAddr_reg <= s_axi_awaddr;
        awHave_reg <= 1'b1;
      end
      if (s_axi_wvalid & s_axi_wready) begin
        wData_reg <= s_axi_wdata;
        wStrb_reg <= s_axi_wstrb;
        wHave_reg <= 1'b1;
      end
      if (doWrite) begin
        awHave_reg   <= 1'b0;
        wHave_reg    <= 1'b0;
        s_axi_bvalid <= 1'b1;
        s_axi_bresp  <= (wrSel == 4'h0) ? `LRT_RESP_DECERR : `LRT_RESP_OKAY;
        if (wrSel[0] & wStrb_reg[0]) begin
          rxThresh_reg <= wData_reg[`LRT_RX_THRESH_LSB +: 8];
        end
        if (wrSel[0] & wStrb_reg[1]) begin
          txCount_reg <= wData_reg[`LRT_TX_COUNT_LSB +: 8];
        end
      end else if (s_axi_bvalid & s_axi_bready) begin
        s_axi_bvalid <= 1'b0;
      end
      s_axi_arready <= s_axi_arvalid & ~s_axi_arready & ~s_axi_rvalid;
      if (s_axi_arvalid & s_axi_arready) begin
        s_axi_rvalid <= 1'b1;
        s_axi_rdata  <= rdMux;
        s_axi_rresp  <= (rdSel == 4'h0) ? `LRT_RESP_DECERR : `LRT_RESP_OKAY;
      end else if (s_axi_rvalid & s_axi_rready) begin
        s_axi_rvalid <= 1'b0;
      end
    end
  end

  // ********************
  // Receive side
  // ********************
  reg [7:0] lastRrp_reg;
  reg [7:0] returnPtr_reg;
  reg [7:0] begCnt_reg;
  reg [7:0] clrCnt_reg;
  reg [7:0] abortTimer_reg;
  reg       pendStart_reg;
  reg       pendReplay_reg;
  reg       startTake;
  reg       replayTake;
  wire rxOk     = rxWordValid & ~rxError;
  wire rxGood   = rxOk & ~errorAbort & ~rxRetryPkt;
  wire rxRetOk  = rxOk & rxRetryPkt;
  wire abortSet = rxWordValid & rxError & ~errorAbort;
  wire begSeen  = rxRetOk & rxFrp[`LRT_FRP_BEGIN_BIT];
  wire clrSeen  = rxRetOk & rxFrp[`LRT_FRP_CLEAR_BIT] & errorAbort;
  wire begHit   = begSeen & (begCnt_reg + 8'h01 >= rxThresh_reg);
  wire clrHit   = clrSeen & (clrCnt_reg + 8'h01 >= rxThresh_reg);
  wire timeout  = errorAbort & ~state_reg[1] &
                  (abortTimer_reg == `LRT_ABORT_WAIT_CYC - 8'd1);

  always @(posedge clk) begin
    if (rst) begin
      errorAbort     <= 1'b0;
      rxOutValid     <= 1'b0;
      rxOutData      <= {DATAPATH_WIDTH{1'b0}};
      lastRrp_reg    <= 8'h00;
      returnPtr_reg  <= 8'h00;
      begCnt_reg     <= 8'h00;
      clrCnt_reg     <= 8'h00;
      abortTimer_reg <= 8'h00;
      pendStart_reg  <= 1'b0;
      pendReplay_reg <= 1'b0;
    end else begin
      // Abort clears once enough error-clear packets arrived
      if (abortSet) begin
        errorAbort <= 1'b1;
      end else if (clrHit) begin
        errorAbort <= 1'b0;
      end
      rxOutValid <= rxGood;
      if (rxGood) begin
        rxOutData     <= rxWordData;
        returnPtr_reg <= rxFrp;
      end
      if (rxOk & (~errorAbort | rxRetryPkt)) begin
        lastRrp_reg <= rxRrp;
      end
      if (begSeen) begin
        begCnt_reg <= begHit ? 8'h00 : begCnt_reg + 8'h01;
      end else if (rxOk) begin
        begCnt_reg <= 8'h00;
      end
      if (clrSeen) begin
        clrCnt_reg <= clrHit ? 8'h00 : clrCnt_reg + 8'h01;
      end else if (rxOk | ~errorAbort) begin
        clrCnt_reg <= 8'h00;
      end
      if (~errorAbort | state_reg[1] | timeout) begin
        abortTimer_reg <= 8'h00;
      end else begin
        abortTimer_reg <= abortTimer_reg + 8'h01;
      end
      // request begin-retry; set wins over take
      pendStart_reg  <= abortSet | timeout | (pendStart_reg & ~startTake);
      pendReplay_reg <= begHit | (pendReplay_reg & ~replayTake);
    end
  end

  // ********************
  // Transmit sequencer
  // ********************
  reg [3:0]  stateNext;
  reg [7:0]  seqCnt_reg;
  reg [7:0]  seqNext;
  reg [7:0]  rdAddr_reg;
  reg [7:0]  rdNext;
  reg [7:0]  wrAddr_reg;
  reg [1:0]  emitFlags;
  reg        emitRetry;
  reg        replayRd;
  reg        retryInc;
  wire       seqDone = (seqCnt_reg + 8'h01 >= txCount_reg);
  wire       accept  = txWordValid & txWordReady;
  wire [7:0] wrNext  = accept ? wrAddr_reg + 8'h01 : wrAddr_reg;
  wire [7:0] usedNext = wrNext - lastRrp_reg;

  always @* begin
    stateNext  = state_reg;
    seqNext    = seqCnt_reg;
    rdNext     = rdAddr_reg;
    emitFlags  = 2'b00;
    emitRetry  = 1'b0;
    replayRd   = 1'b0;
    startTake  = 1'b0;
    replayTake = 1'b0;
    retryInc   = 1'b0;
    case (state_reg)
      ST_NORM: begin
        if (pendStart_reg) begin
          stateNext = ST_BEGIN;
          seqNext   = 8'h00;
          startTake = 1'b1;
        end else if (pendReplay_reg) begin
          stateNext  = ST_CLEAR;
          seqNext    = 8'h00;
          replayTake = 1'b1;
          retryInc   = 1'b1;
        end
      end
      ST_BEGIN: begin
        emitRetry = 1'b1;
        emitFlags = 2'b01;
        seqNext   = seqCnt_reg + 8'h01;
        if (seqDone) begin
          stateNext = ST_NORM;
        end
      end
      ST_CLEAR: begin
        emitRetry = 1'b1;
        emitFlags = 2'b10;
        seqNext   = seqCnt_reg + 8'h01;
        if (seqDone) begin
          stateNext = ST_REPLAY;
          rdNext    = lastRrp_reg;
        end
      end
      ST_REPLAY: begin
        if (rdAddr_reg == wrAddr_reg) begin
          stateNext = ST_NORM;
        end else begin
          replayRd = 1'b1;
          rdNext   = rdAddr_reg + 8'h01;
        end
      end
      default: stateNext = ST_NORM;
    endcase
  end

  // Replay reads never free entries, only the returned pointer does
  wire [DATAPATH_WIDTH-1:0] ramRdData;
  lrt_retry_ram #(
    .WIDTH  (DATAPATH_WIDTH),
    .ADDR_W (`LRT_PTR_W)
  ) u_ram (
    .clk    (clk),
    .wrEn   (accept),
    .wrAddr (wrAddr_reg),
    .wrData (txWordData),
    .rdAddr (rdAddr_reg),
    .rdData (ramRdData)
  );

  // ********************
  // Output pipeline and tokens
  // ********************
  reg                      s1Valid_reg;
  reg                      s1Retry_reg;
  reg                      s1Replay_reg;
  reg [1:0]                s1Flags_reg;
  reg [7:0]                s1Addr_reg;
  reg [DATAPATH_WIDTH-1:0] s1Data_reg;
  reg                      sentMeas_reg;
  reg                      sentSamp_reg;
  wire [DATAPATH_WIDTH-1:0] candData = s1Retry_reg ? {DATAPATH_WIDTH{1'b0}} :
                                       (s1Replay_reg ? ramRdData : s1Data_reg);
  wire [DATAPATH_WIDTH-1:0] rlData;
  wire [10:0] tokAdd = {1'b0, tokens_reg} +
                       (tokenReturnValid ? {1'b0, tokenReturnCount} : 11'h000);
  wire [10:0] tokSub = sentSamp_reg ? {7'h00, FLITS_PER_WORD} : 11'h000;
  wire [10:0] tokRes = (tokAdd > tokSub) ? tokAdd - tokSub : 11'h000;
  // Words still in the pipe are charged before their cost lands
  wire [10:0] fpw11 = {7'h00, FLITS_PER_WORD};
  wire [10:0] inFlight = fpw11 * ({10'h000, accept} + {10'h000, s1Valid_reg & ~s1Retry_reg} +
                                  {10'h000, sentMeas_reg});
  wire tokensOk = (tokRes >= inFlight + fpw11);

  always @(posedge clk) begin
    if (rst) begin
      state_reg      <= ST_NORM;
      seqCnt_reg     <= 8'h00;
      rdAddr_reg     <= 8'h00;
      wrAddr_reg     <= 8'h00;
      retries_reg    <= 32'h0000_0000;
      txWordReady    <= 1'b0;
      s1Valid_reg    <= 1'b0;
      s1Retry_reg    <= 1'b0;
      s1Replay_reg   <= 1'b0;
      s1Flags_reg    <= 2'b00;
      s1Addr_reg     <= 8'h00;
      s1Data_reg     <= {DATAPATH_WIDTH{1'b0}};
      sentMeas_reg   <= 1'b0;
      sentSamp_reg   <= 1'b0;
      tokens_reg     <= `LRT_TOKENS_RST;
      linkTxValid    <= 1'b0;
      linkTxRetryPkt <= 1'b0;
      linkTxData     <= {DATAPATH_WIDTH{1'b0}};
      linkTxFrp      <= 8'h00;
      linkTxRrp      <= 8'h00;
    end else begin
      state_reg   <= stateNext;
      seqCnt_reg  <= seqNext;
      rdAddr_reg  <= rdNext;
      wrAddr_reg  <= wrNext;
      retries_reg <= retries_reg + {31'h0, retryInc};
      txWordReady <= (stateNext == ST_NORM) & tokensOk &
                     (usedNext <= `LRT_BUF_USED_MAX);
      s1Valid_reg  <= accept | emitRetry | replayRd;
      s1Retry_reg  <= emitRetry;
      s1Replay_reg <= replayRd;
      s1Flags_reg  <= emitFlags;
      s1Addr_reg   <= accept ? wrAddr_reg : rdAddr_reg;
      s1Data_reg   <= txWordData;
      sentMeas_reg <= s1Valid_reg & ~s1Retry_reg;
      sentSamp_reg <= sentMeas_reg;
      tokens_reg   <= tokLoad ? wData_reg[9:0] : tokRes[9:0];
      linkTxValid    <= s1Valid_reg;
      linkTxRetryPkt <= s1Retry_reg;
      linkTxData     <= rlData;
      linkTxFrp      <= s1Retry_reg ? {6'h00, s1Flags_reg} : s1Addr_reg;
      linkTxRrp      <= returnPtr_reg;
    end
  end

  // ************************************************************
  // Run-length limiter
  // ************************************************************
  generate
    if (FAR_RECEIVER_AC_COUPLED != 0) begin : g_rl
      reg [7:0] runCnt_reg;
      reg       lastBit_reg;
      wire      same = (candData[0] == lastBit_reg);
      wire      flip = s1Valid_reg & same & (runCnt_reg == `LRT_RUN_LIMIT - 8'h01);
      assign rlData = {candData[DATAPATH_WIDTH-1:1], candData[0] ^ flip};
      always @(posedge clk) begin
        if (rst) begin
          runCnt_reg  <= 8'h00;
          lastBit_reg <= 1'b0;
        end else if (s1Valid_reg) begin
          runCnt_reg  <= (same & ~flip) ? runCnt_reg + 8'h01 : 8'h00;
          lastBit_reg <= rlData[0];
        end
      end
    end else begin : g_norl
      assign rlData = candData;
    end
  endgenerate
endmodule // lrt_link_retry
`default_nettype wire

/* lrt_link_retry_props.sv */
`timescale 1ns/1ps
`default_nettype none
// ************
// Retry and receive path checks
// ************
module lrt_link_retry_props #(
  parameter DATAPATH_WIDTH = 512
) (
  input wire logic                      clk,
  input wire logic                      rst,
  input wire logic [DATAPATH_WIDTH-1:0] txWordData,
  input wire logic                      txWordValid,
  input wire logic                      txWordReady,
  input wire logic [DATAPATH_WIDTH-1:0] linkTxData,
  input wire logic                      linkTxValid,
  input wire logic                      linkTxRetryPkt,
  input wire logic [7:0]                linkTxFrp,
  input wire logic [7:0]                linkTxRrp,
  input wire logic [DATAPATH_WIDTH-1:0] rxWordData,
  input wire logic                      rxWordValid,
  input wire logic                      rxRetryPkt,
  input wire logic                      rxError,
  input wire logic [7:0]                rxFrp,
  input wire logic [DATAPATH_WIDTH-1:0] rxOutData,
  input wire logic                      rxOutValid,
  input wire logic                      errorAbort
);
  wire        begPkt = linkTxValid && linkTxRetryPkt && linkTxFrp[0];
  wire        dataOut = linkTxValid && !linkTxRetryPkt;
  logic [9:0] waitCnt;
  // Bound leaves slack for the start latency of a new series
  always @(posedge clk) begin
    if (rst || !errorAbort || begPkt) waitCnt <= 10'h000;
    else waitCnt <= waitCnt + 10'h001;
  end
  default clocking cb @(posedge clk); endclocking
  default disable iff (rst);
  a_err_to_abort:
    assert property (rxWordValid && rxError && !errorAbort |=> errorAbort)
    else $error("link error did not raise abort");
  a_abort_drops:
    assert property (errorAbort && rxWordValid && !rxRetryPkt |=> !rxOutValid)
    else $error("word delivered during abort");
  a_good_delivered:
    assert property (rxWordValid && !rxError && !rxRetryPkt && !errorAbort |=>
      rxOutValid && rxOutData == $past(rxWordData) ##1 linkTxRrp == $past(rxFrp, 2))
    else $error("good word lost or pointer not kept");
  a_begin_on_abort:
    assert property ($rose(errorAbort) |-> ##[0:30] begPkt)
    else $error("no begin-retry packet after abort");
  a_flag_onehot:
    assert property (linkTxValid && linkTxRetryPkt |-> linkTxFrp[0] != linkTxFrp[1])
    else $error("retry packet flag malformed");
  a_rerequest_bound:
    assert property (waitCnt < 10'h118)
    else $error("abort held without a new begin-retry series");
  a_tx_latency:
    assert property (txWordValid && txWordReady |-> ##2 dataOut &&
      linkTxData == $past(txWordData, 2))
    else $error("accepted word not sent two cycles later");
  a_frp_step:
    assert property (dataOut ##1 dataOut |-> linkTxFrp == $past(linkTxFrp) + 8'h01)
    else $error("buffer address did not step by one");
  c_abort: cover property ($rose(errorAbort));
  c_abort_clear: cover property ($fell(errorAbort));
  c_clear_pkt: cover property (linkTxValid && linkTxRetryPkt && linkTxFrp[1]);
endmodule // lrt_link_retry_props
`default_nettype wire

/* lrt_retry_ram.v */
`timescale 1ns/1ps
`default_nettype none
// ************************************************************
// Retry buffer storage, registered read
// ************************************************************
module lrt_retry_ram #(
  parameter WIDTH  = 512,
  parameter ADDR_W = 8
) (
  input  wire              clk,
  input  wire              wrEn,
  input  wire [ADDR_W-1:0] wrAddr,
  input  wire [WIDTH-1:0]  wrData,
  input  wire [ADDR_W-1:0] rdAddr,
  output reg  [WIDTH-1:0]  rdData
);
  reg [WIDTH-1:0] mem [0:(1<<ADDR_W)-1];

  always @(posedge clk) begin
    if (wrEn) begin
      mem[wrAddr] <= wrData;
    end
    rdData <= mem[rdAddr];
  end
endmodule // lrt_retry_ram
`default_nettype wire

/* tb_top.sv */
`timescale 1ns/1ps
`default_nettype none
module tb_top;
  localparam int DW = 256;
  logic          clk = 1'b0;
  logic          rst = 1'b1;
  logic [7:0]    awA = 8'h00;
  logic [7:0]    arA = 8'h00;
  logic [31:0]   wD = 32'h00000000;
  logic          awV = 1'b0, wV = 1'b0, bR = 1'b0, arV = 1'b0, rR = 1'b0, txV = 1'b0;
  logic [DW-1:0] txD = {DW{1'b0}};
  wire           awRdy, wRdy, bV, arRdy, rV, txRdy, lTxV, lTxR, rxV, rxR, rxE, tokV, rxOV, abort;
  wire [1:0]     bResp, rResp;
  wire [31:0]    rD;
  wire [7:0]     lFrp, lRrp, rxF, rxRr;
  wire [9:0]     tokN;
  wire [DW-1:0]  lTxD, rxD, rxOD;
  int            mismatches = 0, checked = 0, cyc = 0, wr = 0, b = 0, d = 0;
  int            nBeg = 0, nClr = 0, nDat = 0, nOut = 0;

  lrt_link_retry #(.DATAPATH_WIDTH(DW)) lrt_link_retry_i (
    .clk(clk), .rst(rst), .s_axi_awaddr(awA), .s_axi_awvalid(awV), .s_axi_awready(awRdy),
    .s_axi_wdata(wD), .s_axi_wstrb(4'hF), .s_axi_wvalid(wV), .s_axi_wready(wRdy),
    .s_axi_bresp(bResp), .s_axi_bvalid(bV), .s_axi_bready(bR), .s_axi_araddr(arA),
    .s_axi_arvalid(arV), .s_axi_arready(arRdy), .s_axi_rdata(rD), .s_axi_rresp(rResp),
    .s_axi_rvalid(rV), .s_axi_rready(rR), .txWordData(txD), .txWordValid(txV),
    .txWordReady(txRdy), .linkTxData(lTxD), .linkTxValid(lTxV), .linkTxRetryPkt(lTxR),
    .linkTxFrp(lFrp), .linkTxRrp(lRrp), .rxWordData(rxD), .rxWordValid(rxV),
    .rxRetryPkt(rxR), .rxError(rxE), .rxFrp(rxF), .rxRrp(rxRr), .rxOutData(rxOD),
    .rxOutValid(rxOV), .tokenReturnValid(tokV), .tokenReturnCount(tokN), .errorAbort(abort));
  lrt_far_model #(.DW(DW), .TH(4)) lrt_far_model_i (
    .clk(clk), .linkTxValid(lTxV), .linkTxRetryPkt(lTxR), .linkTxFrp(lFrp), .linkTxRrp(lRrp),
    .rxWordData(rxD), .rxWordValid(rxV), .rxRetryPkt(rxR), .rxError(rxE), .rxFrp(rxF),
    .rxRrp(rxRr), .tokenReturnValid(tokV), .tokenReturnCount(tokN));

  // ************
  // Tasks, monitor and scenarios
  // ************
  function automatic logic [DW-1:0] pat(input logic [7:0] a);
    return {8{24'hA5C3E1, a}};
  endfunction
  task automatic chk(input logic [255:0] s, input logic [255:0] e);
    checked++;
    if (s !== e) begin
      mismatches++;
      $display("[ERR] %0t seen %h expected %h", $time, s, e);
    end
  endtask
  task automatic end_sim();
    if (mismatches == 0 && checked > 0) $display("ALL CHECKS OK");
    else $display("CHECKS NOT OK");
    $finish;
  endtask
  task automatic ax(input bit w, input logic [7:0] a, input logic [31:0] v,
                    input logic [1:0] er, input logic [31:0] m = 32'hFFFFFFFF);
    bit done;
    done = 1'b0;
    if (w) begin
      awA <= a;
      wD <= v;
      awV <= 1'b1;
      wV <= 1'b1;
      bR <= 1'b1;
    end else begin
      arA <= a;
      arV <= 1'b1;
      rR <= 1'b1;
    end
    while (!done) begin
      @(posedge clk);
      if (awRdy === 1'b1) awV <= 1'b0;
      if (wRdy === 1'b1) wV <= 1'b0;
      if (arRdy === 1'b1) arV <= 1'b0;
      if ((w ? bV : rV) === 1'b1) begin
        bR <= 1'b0;
        rR <= 1'b0;
        done = 1'b1;
        chk(w ? bResp : rResp, er);
        if (!w) chk(rD & m, v);
      end
    end
    @(posedge clk);
  endtask
  // Holds valid until each word is taken, gives up after cyc edges
  task automatic push(input int n, input int cyc);
    txV <= 1'b1;
    txD <= pat(wr[7:0]);
    repeat (cyc) begin
      @(posedge clk);
      if (txRdy === 1'b1 && n > 0) begin
        wr++;
        n--;
        txD <= pat(wr[7:0]);
        if (n == 0) txV <= 1'b0;
      end
    end
    if (n > 0) txV <= 1'b0;
  endtask

  always @(posedge clk) if (!rst) begin
    if (lTxV === 1'b1 && lTxR === 1'b1) begin
      nBeg += lFrp[0];
      nClr += lFrp[1];
    end
    else if (lTxV === 1'b1) begin
      nDat++;
      chk(lTxD, pat(lFrp));
    end
    if (rxOV === 1'b1) nOut++;
  end
  // one clock serves user and link side
  initial forever #2 clk = ~clk;
  always @(posedge clk) begin
    cyc++;
    if (cyc == 20000) begin
      mismatches++;
      end_sim();
    end
  end

  initial begin
    repeat (16) @(posedge clk);
    rst <= 1'b0;
    @(posedge clk);
    ax(0, 8'h00, 32'h00001410, 2'b00);
    ax(0, 8'h08, 32'h00002104, 2'b00, 32'h0000F73F);
    ax(0, 8'h0C, 32'h00000000, 2'b00);
    ax(0, 8'h10, 32'h00000000, 2'b11);
    ax(1, 8'h10, 32'h00000000, 2'b11);
    ax(1, 8'h00, 32'h00000604, 2'b00);
    ax(0, 8'h00, 32'h00000604, 2'b00);
    ax(1, 8'h04, 32'h00000008, 2'b00);
    push(10, 30);
    chk(wr > 0 && wr <= 4, 1'b1);
    ax(0, 8'h04, 32'd8 - 2 * wr, 2'b00, 32'h000003FF);
    lrt_far_model_i.tokens(10'h0C8);
    lrt_far_model_i.lose = 1'b1;
    push(2, 40);
    for (int r = 0; r < 3; r++) begin
      b = nClr;
      d = nDat;
      if (r == 2) lrt_far_model_i.lose = 1'b0;
      lrt_far_model_i.series(2'b01, 4);
      for (int t = 0; t < 400 && nDat < d + 2; t++) @(posedge clk);
      repeat (20) @(posedge clk);
      chk(nClr - b, 6);
      chk(nDat - d, 2);
    end
    ax(0, 8'h0C, 32'h00000003, 2'b00);
    lrt_far_model_i.stall = 1'b1;
    b = nBeg;
    d = nOut;
    lrt_far_model_i.send(pat(8'h33), 1'b1);
    lrt_far_model_i.send(pat(8'h34), 1'b0);
    ax(0, 8'h08, 32'h00000001, 2'b00, 32'h00000001);
    for (int t = 0; t < 800 && nBeg < b + 12; t++) @(posedge clk);
    chk(nBeg - b >= 12, 1'b1);
    chk(nOut - d, 0);
    lrt_far_model_i.stall = 1'b0;
    for (int t = 0; t < 800 && nOut < d + 2; t++) @(posedge clk);
    repeat (10) @(posedge clk);
    chk(abort, 1'b0);
    chk(nOut - d, 2);
    end_sim();
  end
endmodule // tb_top

bind lrt_link_retry lrt_link_retry_props #(.DATAPATH_WIDTH(DATAPATH_WIDTH)) lrt_link_retry_props_i (
  .*);
`default_nettype wire
